/* File: inc/ssp_pkg.sv */
// Constants shared by the serial port status and data block.
// Summary of operation
// - Done flag, status bit 7, sets at byte end, clears when busy or by sequence.
// - Collision flag, status bit 6, sets on collision, clears by sequence.
// - Slave error, bit 5, sets on select release mid byte; only disabling clears.
// - Mode fault, bit 4, sets on wrong select level; clears by sequence.
// - Status bits 3 to 0 reserved; software never writes ones there.
// - After reset done, collision and fault flags read zero.
// - Control register resets to 0001 0100b.
// - Data write loads the shift register directly; no transmit buffer.
// - Data read returns the receive buffer, never the live shift register.
// - Data register is eight bits of received data.
// - All three registers are freely accessible while no exchange runs.
// - Clearing enable stops the peripheral at once, even mid exchange.
// - Data write during a transfer counts as a write collision, not a load.
// - Fault clears by status read with fault set, then control write.
// - Collision clears by status then data access; no interrupt, no stop.
// - Fault raises error request, clears enable and master; needs select enabled.
// - Done flag drives the transmitter interrupt request.
package ssp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTL = 8'hC3;
    localparam logic [7:0] IDX_STAT = 8'hC4;
    localparam logic [7:0] IDX_DATA = 8'hC5;
    localparam logic [7:0] IDX_MASK = 8'hC6;
    localparam logic [7:0] IDX_EVT = 8'hC7;
    // Status bit positions
    localparam int ST_DONE = 7;
    localparam int ST_WRITE_COLLISION_FLAG = 6;
    localparam int ST_SLAVE_SELECT_ERROR_FLAG = 5;
    localparam int ST_MODE_FAULT_FLAG = 4;
    // Control bit positions
    localparam int CT_RATE_HI = 7;
    localparam int CT_EN = 6;
    localparam int CT_SELECT_LINE_DISABLE = 5;
    localparam int CT_MASTER_SELECT = 4;
    localparam int CT_CLOCK_POLARITY = 3;
    localparam int CT_CLOCK_PHASE = 2;
    localparam int CT_RATE_MID = 1;
    localparam int CT_RATE_LO = 0;
    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h14;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Clock edges in one byte exchange
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
endpackage : ssp_pkg

/* File: rtl/ssp_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
    parameter int W = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : ssp_sync
`default_nettype wire

/* File: rtl/ssp_core.sv */
// Serial port engine with status, data and control registers on AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module ssp_core (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_out,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_out,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_out,
    input wire logic ss_b_in,
    output logic irq_out,
    output logic tx_irq_out,
    output logic err_irq_out
);
    logic [3:0] pins_s;
    logic sck_s, mosi_s, miso_s, ss_b_s;
    logic dph_r, dph_wr_r, dph_hit_r;
    logic [7:0] dph_idx_r;
    logic [7:0] ctl_r, rxbuf_r, sh_r, mask_r, evt_r;
    logic done_r, write_collision_flag_r, slave_select_error_flag_r, mode_fault_flag_r;
    logic done_arm_r, write_collision_flag_arm_r, mode_fault_flag_arm_r;
    logic busy_r, out_r, sck_r, sck_prev_r, ss_prev_r;
    logic [4:0] cnt_r;
    logic [6:0] div_r;
    logic [2:0] rate;
    logic [6:0] half;
    logic en, master_select, clock_polarity, clock_phase, select_line_disable, sel, din;
    logic wr_ctl, wr_data, wr_mask, wr_evt, rd_stat, acc_stat, acc_data;
    logic m_edge, s_edge, edge_ev, sample, last_edge, start, fault;
    logic slave_select_error_flag_ev, write_collision_flag_ev;
    logic [7:0] sh_in, stat_val;

    // Pins cross into the bus clock domain
    ssp_sync #(.W(4)) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .d_in({sck_in, mosi_in, miso_in, ss_b_in}),
        .q_out(pins_s)
    );
    assign {sck_s, mosi_s, miso_s, ss_b_s} = pins_s;

    // Control fields
    assign en = ctl_r[ssp_pkg::CT_EN];
    assign master_select = ctl_r[ssp_pkg::CT_MASTER_SELECT];
    assign clock_polarity = ctl_r[ssp_pkg::CT_CLOCK_POLARITY];
    assign clock_phase = ctl_r[ssp_pkg::CT_CLOCK_PHASE];
    assign select_line_disable = ctl_r[ssp_pkg::CT_SELECT_LINE_DISABLE];
    assign rate = {ctl_r[ssp_pkg::CT_RATE_HI], ctl_r[ssp_pkg::CT_RATE_MID],
                   ctl_r[ssp_pkg::CT_RATE_LO]};
    // Invalid rate codes fall back to the nearest legal divider
    always_comb begin
        unique case (rate)
            3'h0: half = 7'h01;
            3'h7: half = 7'h3F;
            default: half = 7'((7'h01 << rate) - 7'h01);
        endcase
    end

    // Register accesses take effect in the first data phase cycle
    assign wr_ctl = dph_r && dph_wr_r && dph_hit_r && dph_idx_r == ssp_pkg::IDX_CTL;
    assign wr_data = dph_r && dph_wr_r && dph_hit_r && dph_idx_r == ssp_pkg::IDX_DATA;
    assign wr_mask = dph_r && dph_wr_r && dph_hit_r && dph_idx_r == ssp_pkg::IDX_MASK;
    assign wr_evt = dph_r && dph_wr_r && dph_hit_r && dph_idx_r == ssp_pkg::IDX_EVT;
    assign acc_stat = dph_r && dph_hit_r && dph_idx_r == ssp_pkg::IDX_STAT;
    assign acc_data = dph_r && dph_hit_r && dph_idx_r == ssp_pkg::IDX_DATA;
    assign rd_stat = acc_stat && !dph_wr_r;

    // Link events; both ends count sixteen clock edges per byte
    assign sel = !ss_b_s || (select_line_disable && clock_phase);
    assign m_edge = busy_r && master_select && div_r == 7'h00;
    assign s_edge = en && !master_select && sel && sck_s != sck_prev_r;
    assign edge_ev = m_edge || s_edge;
    assign sample = cnt_r[0] == clock_phase;
    assign last_edge = edge_ev && cnt_r == ssp_pkg::EDGES_PER_BYTE - 5'h01;
    assign din = master_select ? miso_s : mosi_s;
    assign sh_in = {sh_r[6:0], din};
    assign start = wr_data && !busy_r && en && master_select;
    assign fault = en && master_select && !select_line_disable && !ss_b_s;
    assign slave_select_error_flag_ev = en && !master_select && busy_r && ss_b_s && !ss_prev_r;
    assign write_collision_flag_ev = wr_data && busy_r;
    assign stat_val = {done_r, write_collision_flag_r, slave_select_error_flag_r, mode_fault_flag_r, 4'h0};

    // Bus address phase capture; every access gets one wait state
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dph_r <= 1'b0;
            dph_wr_r <= 1'b0;
            dph_hit_r <= 1'b0;
            dph_idx_r <= 8'h00;
            hreadyout_out <= 1'b1;
        end else if (hready_in && hsel_in && htrans_in[1]) begin
            dph_r <= 1'b1;
            dph_wr_r <= hwrite_in;
            dph_hit_r <= haddr_in[31:10] == 22'h000000 && haddr_in[1:0] == 2'h0;
            dph_idx_r <= haddr_in[9:2];
            hreadyout_out <= 1'b0;
        end else begin
            dph_r <= 1'b0;
            hreadyout_out <= 1'b1;
        end
    end

    // Read data; unmapped offsets read zero, response always OKAY
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hrdata_out <= 32'h00000000;
            hresp_out <= 1'b0;
        end else if (dph_r && !dph_wr_r) begin
            hresp_out <= 1'b0;
            if (!dph_hit_r) begin
                hrdata_out <= 32'h00000000;
            end else begin
                unique case (dph_idx_r)
                    ssp_pkg::IDX_CTL: hrdata_out <= {24'h000000, ctl_r};
                    ssp_pkg::IDX_STAT: hrdata_out <= {24'h000000, stat_val};
                    ssp_pkg::IDX_DATA: hrdata_out <= {24'h000000, rxbuf_r};
                    ssp_pkg::IDX_MASK: hrdata_out <= {24'h000000, mask_r};
                    ssp_pkg::IDX_EVT: hrdata_out <= {24'h000000, evt_r};
                    default: hrdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // Control register; a fault drops enable and master at once
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_r <= ssp_pkg::CTL_RESET;
        end else if (fault) begin
            ctl_r[ssp_pkg::CT_EN] <= 1'b0;
            ctl_r[ssp_pkg::CT_MASTER_SELECT] <= 1'b0;
        end else if (wr_ctl) begin
            ctl_r <= hwdata_in[7:0]; // software keeps fields steady
        end
    end

    // Transfer done flag: set wins over the clearing sequence
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_r <= 1'b0;
            done_arm_r <= 1'b0;
        end else begin
            if (last_edge) begin
                done_r <= 1'b1;
            end else if (start || (busy_r && edge_ev)) begin
                done_r <= 1'b0; // cleared while in progress
            end else if (acc_data && done_arm_r) begin
                done_r <= 1'b0;
            end
            if (rd_stat) begin
                done_arm_r <= done_r;
            end else if (acc_data) begin
                done_arm_r <= 1'b0;
            end
        end
    end

    // Collision flag; the running byte is left alone
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            write_collision_flag_r <= 1'b0;
            write_collision_flag_arm_r <= 1'b0;
        end else begin
            if (write_collision_flag_ev) begin
                write_collision_flag_r <= 1'b1;
            end else if (acc_data && write_collision_flag_arm_r) begin
                write_collision_flag_r <= 1'b0;
            end
            if (acc_stat) begin
                write_collision_flag_arm_r <= 1'b1;
            end else if (acc_data) begin
                write_collision_flag_arm_r <= 1'b0;
            end
        end
    end

    // Slave error and mode fault flags
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slave_select_error_flag_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
            mode_fault_flag_arm_r <= 1'b0;
        end else begin
            if (slave_select_error_flag_ev) begin
                slave_select_error_flag_r <= 1'b1;
            end else if (wr_ctl && !hwdata_in[ssp_pkg::CT_EN]) begin
                slave_select_error_flag_r <= 1'b0; // only disabling clears it
            end
            if (fault) begin
                mode_fault_flag_r <= 1'b1;
            end else if (wr_ctl && mode_fault_flag_arm_r) begin
                mode_fault_flag_r <= 1'b0;
            end
            if (rd_stat) begin
                mode_fault_flag_arm_r <= mode_fault_flag_r;
            end else if (wr_ctl) begin
                mode_fault_flag_arm_r <= 1'b0;
            end
        end
    end

    // Shift engine; the receive buffer only updates at byte end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
            sh_r <= ssp_pkg::DATA_RESET;
            rxbuf_r <= ssp_pkg::DATA_RESET;
            out_r <= 1'b0;
        end else if (!en) begin
            busy_r <= 1'b0; // stops at once
            cnt_r <= 5'h00;
            if (wr_data) begin
                sh_r <= hwdata_in[7:0];
            end
        end else if (slave_select_error_flag_ev) begin
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
        end else if (wr_data && !busy_r) begin
            sh_r <= hwdata_in[7:0];
            busy_r <= master_select;
            out_r <= hwdata_in[7];
        end else if (edge_ev) begin
            busy_r <= !last_edge;
            cnt_r <= last_edge ? 5'h00 : cnt_r + 5'h01;
            if (sample) begin
                sh_r <= sh_in;
            end else begin
                out_r <= sh_r[7];
            end
            if (last_edge) begin
                rxbuf_r <= sample ? sh_in : sh_r;
            end
        end else if (!busy_r) begin
            out_r <= sh_r[7];
        end
    end

    // Master clock divider and pin levels
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_r <= 7'h00;
            sck_r <= 1'b0;
            sck_prev_r <= 1'b0;
            ss_prev_r <= 1'b1;
        end else begin
            sck_prev_r <= sck_s;
            ss_prev_r <= ss_b_s;
            if (!busy_r || !master_select) begin
                div_r <= half;
                sck_r <= clock_polarity;
            end else if (m_edge) begin
                div_r <= half;
                sck_r <= !sck_r;
            end else begin
                div_r <= div_r - 7'h01;
            end
        end
    end

    // Pin drivers; slave drives its output only while selected
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_out <= 1'b0;
            sck_oe_out <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe_out <= 1'b0;
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
        end else begin
            sck_out <= sck_r;
            sck_oe_out <= en && master_select;
            mosi_out <= out_r;
            mosi_oe_out <= en && master_select;
            miso_out <= out_r;
            miso_oe_out <= en && !master_select && !ss_b_s;
        end
    end

    // Event capture, write one to clear; set wins over clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evt_r <= 8'h00;
            mask_r <= ssp_pkg::MASK_RESET;
        end else begin
            if (wr_mask) begin
                mask_r <= hwdata_in[7:0] & 8'hB0; // no collision irq
            end
            evt_r <= (wr_evt ? (evt_r & ~hwdata_in[7:0]) : evt_r)
                     | {last_edge, write_collision_flag_ev, slave_select_error_flag_ev, fault, 4'h0};
        end
    end

    // Interrupt requests; a collision raises none of them
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_out <= 1'b0;
            tx_irq_out <= 1'b0;
            err_irq_out <= 1'b0;
        end else begin
            irq_out <= |(evt_r & mask_r);
            tx_irq_out <= done_r;
            err_irq_out <= mode_fault_flag_r && !select_line_disable;
        end
    end

    // Size is fixed at word access; only the low byte is used
    logic unused_ok;
    assign unused_ok = ^{hsize_in, hwdata_in[31:8]};
endmodule : ssp_core
`default_nettype wire

/* File: bench/ssp_core_monitor.sv */
// Bus and pin checks for the serial port core
`timescale 1ns/1ps
`default_nettype none
module ssp_core_monitor (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [31:0] hrdata_out,
    input wire logic ss_b_in,
    input wire logic sck_out,
    input wire logic sck_oe_out,
    input wire logic mosi_oe_out,
    input wire logic miso_oe_out,
    input wire logic tx_irq_out,
    input wire logic err_irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic tk;
    // Address phase accepted by the slave
    assign tk = hsel_in && hready_in && htrans_in[1];
    sequence rd_at(a);
        tk && !hwrite_in && haddr_in == a;
    endsequence
    a_bus_wait: assert property (tk |=> !hreadyout_out ##1 hreadyout_out)
        else $error("bus wait state out of place");
    a_resp_okay: assert property (hresp_out == 1'b0)
        else $error("bus response not okay");
    a_status_rsvd: assert property (rd_at(32'h310) |-> ##2
        hrdata_out[3:0] == 4'h0 && hrdata_out[31:8] == 24'h0)
        else $error("status reserved bits not zero");
    a_data_width: assert property (rd_at(32'h314) |-> ##2
        hrdata_out[31:8] == 24'h0) else $error("data wider than a byte");
    a_disable_stop: assert property ((tk && hwrite_in &&
        haddr_in == 32'h30C) ##1 !hwdata_in[6] |-> ##[0:3]
        !(sck_oe_out || mosi_oe_out || miso_oe_out))
        else $error("pins still driven after disable");
    a_fault_drop: assert property (err_irq_out |-> ##[0:2]
        !mosi_oe_out && !sck_oe_out) else $error("master kept after fault");
    a_fault_cause: assert property ($rose(err_irq_out) |->
        !$past(ss_b_in, 2) || !$past(ss_b_in, 3) || !$past(ss_b_in, 4))
        else $error("fault without low select");
    a_done_idle: assert property ($rose(tx_irq_out) && sck_oe_out |=>
        $stable(sck_out) [*4]) else $error("clock moves after byte end");
    // Main scenarios reached
    cover property (tk && hwrite_in && haddr_in == 32'h314);
    cover property ($rose(tx_irq_out));
    cover property ($rose(err_irq_out));
endmodule : ssp_core_monitor
bind ssp_core ssp_core_monitor u_mon (.clk_in, .rst_b_in, .hsel_in,
    .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
    .hreadyout_out, .hresp_out, .hrdata_out, .ss_b_in, .sck_out,
    .sck_oe_out, .mosi_oe_out, .miso_oe_out, .tx_irq_out, .err_irq_out);
`default_nettype wire

/* File: bench/ssp_peer.sv */
// Far side serial device: slave to the core, or master at the link rate
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic sel_b_in,
    input wire logic go_in,
    input wire logic [3:0] nbits_in,
    input wire logic [7:0] tx_in,
    output logic sck_out,
    output logic mosi_out,
    output logic miso_out,
    output logic ss_b_out,
    output logic [7:0] rx_out
);
    logic [7:0] sh_r;
    int i;
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        miso_out = 1'b0;
        ss_b_out = 1'b1;
        rx_out = 8'h00;
    end
    // Slave role, mode 0: first bit out on select, MSB first
    always @(negedge sel_b_in) begin
        sh_r = tx_in;
        miso_out = tx_in[7];
    end
    always @(posedge sck_in) if (!sel_b_in) rx_out = {rx_out[6:0], mosi_in};
    always @(negedge sck_in) begin
        if (!sel_b_in) begin
            sh_r = sh_r << 1;
            miso_out = sh_r[7];
        end
    end
    // Released line has no pull, so it shows the opposite level
    always @(posedge sel_b_in) miso_out = ~miso_out;
    // Master role; clock stands low outside frames, odd phase to clk
    always @(posedge go_in) begin
        #7;
        ss_b_out = 1'b0;
        for (i = 0; i < nbits_in; i++) begin
            mosi_out = tx_in[7 - i];
            #80;
            sck_out = 1'b1;
            rx_out = {rx_out[6:0], miso_in};
            #80;
            sck_out = 1'b0;
        end
        #80;
        ss_b_out = 1'b1;
        mosi_out = ~mosi_out;
    end
endmodule : ssp_peer
`default_nettype wire

/* File: bench/spi_status_and_data_port_tb.sv */
// Self-checking bench for the serial port status and data block
`timescale 1ns/1ps
`default_nettype none
module spi_status_and_data_port_tb;
    localparam logic [31:0] A_CTL = {22'h0, ssp_pkg::IDX_CTL, 2'h0};
    localparam logic [31:0] A_STAT = {22'h0, ssp_pkg::IDX_STAT, 2'h0};
    localparam logic [31:0] A_DATA = {22'h0, ssp_pkg::IDX_DATA, 2'h0};
    localparam logic [31:0] A_MASK = {22'h0, ssp_pkg::IDX_MASK, 2'h0};
    localparam logic [31:0] A_EVT = {22'h0, ssp_pkg::IDX_EVT, 2'h0};
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, fault_r = 1'b0, go = 1'b0;
    logic psel_b = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [3:0] nbits = 4'h8;
    logic [7:0] ptx = 8'h3C, prx;
    logic hrdy, hresp, irq, tx_irq, err_irq;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic p_sck, p_mosi, p_miso, p_ss_b, sck_w, mosi_w, miso_w;
    int bad_count = 0;
    int num_checks = 0;
    // Each line shows whichever party enables onto it
    assign sck_w = sck_oe ? sck_o : p_sck;
    assign mosi_w = mosi_oe ? mosi_o : p_mosi;
    assign miso_w = miso_oe ? miso_o : p_miso;
    always #10 clk_in = ~clk_in;
    ssp_core DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe),
        .ss_b_in(p_ss_b & ~fault_r), .irq_out(irq), .tx_irq_out(tx_irq),
        .err_irq_out(err_irq));
    ssp_peer u_peer (.sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w),
        .sel_b_in(psel_b), .go_in(go), .nbits_in(nbits), .tx_in(ptx),
        .sck_out(p_sck), .mosi_out(p_mosi), .miso_out(p_miso),
        .ss_b_out(p_ss_b), .rx_out(prx));
    task results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One AHB single; d is write data, or the expected word of a read
    task acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do begin @(posedge clk_in); n++; end while (hrdy !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk_in); n++; end while (hrdy !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        if (!wr) chk(hrdata, d);
    endtask : acc
    task wait_done;
        int n;
        n = 0;
        while (tx_irq !== 1'b1 && n < 2000) begin @(posedge clk_in); n++; end
        chk({31'h0, tx_irq}, 32'h1);
    endtask : wait_done
    // Peer-mastered frame of nb bits, returns once select is released
    task frame(input logic [3:0] nb, input logic [7:0] tx);
        int n;
        n = 0;
        nbits <= nb;
        ptx <= tx;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        while (p_ss_b !== 1'b1 && n < 500) begin @(posedge clk_in); n++; end
        if (n >= 500) bad_count++;
        // Let the synchronised select release reach the flags
        repeat (4) @(posedge clk_in);
    endtask : frame
    task fault_pulse;
        fault_r <= 1'b1;
        repeat (8) @(posedge clk_in);
        fault_r <= 1'b0;
    endtask : fault_pulse
    // Hang guard, well beyond the expected run
    initial begin
        #200000;
        bad_count++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        acc(0, A_CTL, 32'h14);
        acc(0, A_STAT, 32'h0);
        acc(0, A_DATA, 32'h0);
        acc(0, 32'h400, 32'h0);
        // Master byte with a colliding second write
        acc(1, A_MASK, 32'h80);
        acc(1, A_CTL, 32'h53);
        psel_b <= 1'b0;
        acc(1, A_DATA, 32'hA5);
        acc(1, A_DATA, 32'h5A);
        acc(0, A_STAT, 32'h40);
        wait_done();
        chk({31'h0, irq}, 32'h1);
        acc(0, A_STAT, 32'hC0);
        acc(0, A_DATA, 32'h3C);
        acc(0, A_STAT, 32'h0);
        chk({24'h0, prx}, 32'hA5);
        acc(0, A_EVT, 32'hC0);
        acc(1, A_MASK, 32'h40);
        acc(0, A_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        acc(1, A_MASK, 32'h80);
        acc(1, A_EVT, 32'hC0);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        // Disable in mid byte, rate and mode bits untouched
        acc(1, A_DATA, 32'h11);
        acc(1, A_CTL, 32'h13);
        repeat (200) @(posedge clk_in);
        acc(0, A_STAT, 32'h0);
        psel_b <= 1'b1;
        // Slave byte clocked by the peer
        acc(1, A_CTL, 32'h40);
        acc(1, A_DATA, 32'h96);
        frame(4'h8, 8'hC3);
        wait_done();
        acc(0, A_STAT, 32'h80);
        acc(0, A_DATA, 32'hC3);
        chk({24'h0, prx}, 32'h96);
        frame(4'h4, 8'hF0);
        acc(0, A_STAT, 32'h20);
        acc(1, A_CTL, 32'h00);
        acc(0, A_STAT, 32'h0);
        // Select low ignored while select is disabled
        acc(1, A_CTL, 32'h73);
        fault_pulse();
        acc(0, A_STAT, 32'h0);
        acc(1, A_MASK, 32'h00);
        acc(1, A_CTL, 32'h53);
        fault_pulse();
        chk({31'h0, err_irq}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        acc(0, A_CTL, 32'h03);
        acc(0, A_STAT, 32'h10);
        acc(1, A_CTL, 32'h13);
        acc(0, A_STAT, 32'h0);
        chk({31'h0, err_irq}, 32'h0);
        acc(1, A_MASK, 32'h10);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h1);
        acc(1, A_EVT, 32'h10);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        results();
    end
endmodule : spi_status_and_data_port_tb
`default_nettype wire
